// ---- tcp_pkg.sv ----
// Constants shared by the timing coprocessor core and its channel module.
// Assumes a single 25 MHz clock and synchronous active-high reset.
//
// Summary of operation
// - 512-byte register space, unused reads give zero
// - Two 16-bit time bases, host-set prescalers
// - Time bases visible to channels only
// - Base one from clock, two optionally external
// - Sixteen channels with capture, compare, comparator
// - Engine sets each pin direction
// - Separate time base for match and capture
// - Service request from one of four causes
// - Three priority levels, ties in rotating channel order
// - Events request service, granted when engine free
// - Channel events run concurrently, independent of service
// - Microcode from internal ROM or emulation RAM
// - 128-word parameter RAM shared by all channels
// - 16-byte blocks, six or eight words used
// - Host writes parameters, engine reads and writes results
// - Control word field forces pin level
// - Control word field picks edge or match level
// - Control word field picks direction and time bases
// - Host interface reachable before and during execution
// - Same-level requests served in rotating channel order
// - Coherent access to two adjacent words
package tcp_pkg;
    // ==========================================================
    // Sizes
    localparam int TB_W = 16;
    localparam int NCH = 16;
    localparam int PRAM_WORDS = 128;
    localparam int REG_ADDR_W = 9;
    localparam int CODE_ADDR_W = 6;
    localparam logic [15:0] TB_RST = 16'h0000;
    localparam logic [7:0] TB_DIV_ALL = 8'hff;
    localparam logic [2:0] TB_DIV_SHIFT = 3'h6;
    // ==========================================================
    // Channel control word fields
    localparam int CTL_FORCE_LSB = 0;
    localparam int CTL_ACT_LSB = 2;
    localparam int CTL_DIR_BIT = 4;
    localparam int CTL_MTB_BIT = 5;
    localparam int CTL_CTB_BIT = 6;
    localparam logic [1:0] FORCE_HIGH = 2'h1;
    localparam logic [1:0] FORCE_LOW = 2'h2;
    localparam logic [1:0] ACT_RISE_HIGH = 2'h1;
    localparam logic [1:0] ACT_FALL_LOW = 2'h2;
    localparam logic [1:0] ACT_BOTH_TOGGLE = 2'h3;
    // ==========================================================
    // Parameter RAM layout, word units
    localparam logic [2:0] PW_CTL = 3'h0;
    localparam logic [2:0] PW_CMP = 3'h1;
    localparam logic [2:0] PW_RES = 3'h2;
    localparam logic [2:0] PW_SHORT = 3'h6;
    localparam logic [3:0] LONG_FIRST_CH = 4'he;
    // ==========================================================
    // Function code word fields
    localparam int CODE_LINK_EN = 4;
    localparam int CODE_WR_CAP = 5;
    localparam int CODE_LD_CMP = 6;
    localparam logic [15:0] CODE_ARM = 16'h0040;
    localparam logic [15:0] CODE_RESULT = 16'h0020;
    // ==========================================================
    // Host register offsets (bytes) and priority codes
    localparam logic [8:0] REG_CFG = 9'h000;
    localparam logic [8:0] REG_PRI_LO = 9'h004;
    localparam logic [8:0] REG_PRI_HI = 9'h006;
    localparam logic [8:0] REG_PEND = 9'h008;
    localparam logic [8:0] REG_GRANT = 9'h00a;
    localparam logic [1:0] PRI_OFF = 2'h0;
    typedef enum logic [1:0] {CAUSE_HOST, CAUSE_LINK, CAUSE_MATCH, CAUSE_CAPT} tcp_cause_e;
endpackage

// ---- tcp_chan_if.sv ----
// Connection between the core and one timer channel.
// One instance per channel; the core drives config, the channel reports events.
`timescale 1ns/1ps
interface tcp_chan_if;
    logic [15:0] tb1;
    logic [15:0] tb2;
    logic cfg_load;
    logic [15:0] cfg_word;
    logic cmp_load;
    logic [15:0] cmp_val;
    logic pin_in;
    logic pin_out;
    logic pin_oe_n;
    logic match_ev;
    logic cap_ev;
    logic [15:0] cap_val;
    modport core (output tb1, tb2, cfg_load, cfg_word, cmp_load, cmp_val, pin_in,
                  input pin_out, pin_oe_n, match_ev, cap_ev, cap_val);
    modport chan (input tb1, tb2, cfg_load, cfg_word, cmp_load, cmp_val, pin_in,
                  output pin_out, pin_oe_n, match_ev, cap_ev, cap_val);
endinterface

// ---- tcp_chan.sv ----
// One timer channel: event register, comparator and pin control.
// Assumes config and compare loads arrive as one-cycle strobes from the core.
`timescale 1ns/1ps
module tcp_chan
(
    input wire logic clk,
    input wire logic rst,
    tcp_chan_if.chan cif
);
    typedef struct packed {
        logic dir;
        logic mtb;
        logic ctb;
        logic [1:0] act;
        logic [15:0] cmp;
        logic armed;
        logic [15:0] cap;
        logic pin_q;
        logic out;
        logic match_ev;
        logic cap_ev;
    } tcp_chan_s;

    tcp_chan_s s_r;
    tcp_chan_s s_nxt;

    // Half-range compare so the test survives counter wrap
    function automatic logic tcp_ge(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] d;
        d = a - b;
        return ~d[15];
    endfunction

    // ==========================================================
    // Event logic, runs every cycle regardless of service
    always_comb
    begin
        logic [15:0] mt;
        logic [15:0] ct;
        logic rise;
        logic fall;
        mt = '0;
        ct = '0;
        rise = 1'b0;
        fall = 1'b0;
        s_nxt = s_r;
        s_nxt.match_ev = 1'b0;
        s_nxt.cap_ev = 1'b0;
        s_nxt.pin_q = cif.pin_in;
        mt = s_r.mtb ? cif.tb2 : cif.tb1;
        ct = s_r.ctb ? cif.tb2 : cif.tb1;
        rise = cif.pin_in & ~s_r.pin_q;
        fall = ~cif.pin_in & s_r.pin_q;
        // Match fires once per arming on a greater-or-equal compare
        if (s_r.armed && tcp_ge(mt, s_r.cmp))
        begin
            s_nxt.match_ev = 1'b1;
            s_nxt.armed = 1'b0;
            s_nxt.cap = ct;
            if (s_r.dir)
            begin
                case (s_r.act)
                    tcp_pkg::ACT_RISE_HIGH: s_nxt.out = 1'b1;
                    tcp_pkg::ACT_FALL_LOW: s_nxt.out = 1'b0;
                    tcp_pkg::ACT_BOTH_TOGGLE: s_nxt.out = ~s_r.out;
                    default: s_nxt.out = s_r.out;
                endcase
            end
        end
        // Input capture on the selected edge
        if (!s_r.dir && ((rise && s_r.act[0]) || (fall && s_r.act[1])))
        begin
            s_nxt.cap = ct;
            s_nxt.cap_ev = 1'b1;
        end
        if (cif.cfg_load)
        begin
            s_nxt.dir = cif.cfg_word[tcp_pkg::CTL_DIR_BIT];
            s_nxt.mtb = cif.cfg_word[tcp_pkg::CTL_MTB_BIT];
            s_nxt.ctb = cif.cfg_word[tcp_pkg::CTL_CTB_BIT];
            s_nxt.act = cif.cfg_word[tcp_pkg::CTL_ACT_LSB +: 2];
            case (cif.cfg_word[tcp_pkg::CTL_FORCE_LSB +: 2])
                tcp_pkg::FORCE_HIGH: s_nxt.out = 1'b1;
                tcp_pkg::FORCE_LOW: s_nxt.out = 1'b0;
                default: s_nxt.out = s_nxt.out;
            endcase
        end
        if (cif.cmp_load)
        begin
            s_nxt.cmp = cif.cmp_val;
            s_nxt.armed = 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // Outputs all come from flops
    assign cif.pin_out = s_r.out;
    assign cif.pin_oe_n = ~s_r.dir;
    assign cif.match_ev = s_r.match_ev;
    assign cif.cap_ev = s_r.cap_ev;
    assign cif.cap_val = s_r.cap;
endmodule // tcp_chan

// ---- tcp_core.sv ----
// Timing coprocessor core: time bases, scheduler, engine, parameter RAM.
// Assumes all inputs synchronous to clk; host ports are plain, no bus.
`timescale 1ns/1ps
module tcp_core
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] cfg_tb1_prescale,
    input wire logic [1:0] cfg_tb2_prescale,
    input wire logic cfg_tb2_ext_sel,
    input wire logic external_time_base_clock_pin,
    input wire logic [31:0] channel_priority,
    input wire logic [15:0] host_service_request,
    input wire logic emu_select,
    output logic [5:0] ucode_addr,
    input wire logic [15:0] ucode_emu_data,
    input wire logic [6:0] pram_addr,
    input wire logic pram_long,
    input wire logic pram_wr,
    input wire logic pram_rd,
    input wire logic [31:0] pram_wdata,
    output logic [31:0] pram_rdata,
    input wire logic [8:0] reg_addr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe_n,
    output logic service_busy,
    output logic [3:0] service_chan
);
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} tcp_state_e;

    typedef struct packed {
        logic [15:0] tb1;
        logic [15:0] tb2;
        logic [7:0] pre1;
        logic [7:0] pre2;
        logic ext_q;
        logic [3:0][15:0] pend;
        logic [2:0][3:0] last;
        tcp_state_e st;
        logic [3:0] chan;
        tcp_pkg::tcp_cause_e cause;
        logic [15:0] code;
        logic [15:0] ctl;
        logic [15:0] cmp;
        logic [127:0][15:0] pram;
        logic [31:0] host_rd;
        logic [15:0] reg_rd;
    } tcp_core_s;

    tcp_core_s s_r;
    tcp_core_s s_nxt;

    logic [15:0] match_ev;
    logic [15:0] cap_ev;
    logic [15:0][15:0] cap_val;
    logic [15:0] pin_out_w;
    logic [15:0] pin_oe_w;

    tcp_chan_if ch_if[tcp_pkg::NCH]();

    // ==========================================================
    // Helpers

    // Prescaler mask: divide by 4, 8, 16 or 32
    function automatic logic [7:0] tcp_div_mask(input logic [1:0] p);
        return tcp_pkg::TB_DIV_ALL >> (tcp_pkg::TB_DIV_SHIFT - {1'b0, p});
    endfunction

    // Parameter word exists only in implemented slots of each 16-byte block
    function automatic logic tcp_impl(input logic [6:0] a);
        return (a[6:3] >= tcp_pkg::LONG_FIRST_CH) || (a[2:0] < tcp_pkg::PW_SHORT);
    endfunction

    // Word address of one word inside a channel block
    function automatic logic [6:0] tcp_pw(input logic [3:0] ch, input logic [2:0] w);
        return {ch, w};
    endfunction

    // First set bit strictly after ptr, cyclically; ptr itself comes last
    function automatic logic [3:0] tcp_next(input logic [15:0] m, input logic [3:0] ptr);
        logic [3:0] r;
        logic [3:0] idx;
        logic hit;
        r = ptr;
        idx = ptr;
        hit = 1'b0;
        for (int i = 1; i <= 16; i++)
        begin
            idx = ptr + 4'(i);
            if (!hit && m[idx])
            begin
                r = idx;
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    // Internal control store, indexed by cause then channel
    function automatic logic [15:0] tcp_rom(input logic [5:0] a);
        logic [15:0] w;
        w = '0;
        case (a[5:4])
            2'h0: w = tcp_pkg::CODE_ARM;
            2'h1: w = tcp_pkg::CODE_ARM;
            2'h2: w = tcp_pkg::CODE_RESULT;
            2'h3: w = tcp_pkg::CODE_RESULT | tcp_pkg::CODE_ARM;
            default: w = '0;
        endcase
        return w;
    endfunction

    // ==========================================================
    // Channels: each runs its own event hardware
    genvar g;
    generate
        for (g = 0; g < tcp_pkg::NCH; g++)
        begin : g_ch
            assign ch_if[g].tb1 = s_r.tb1;
            assign ch_if[g].tb2 = s_r.tb2;
            assign ch_if[g].pin_in = pin_in[g];
            assign ch_if[g].cfg_load = (s_r.st == ST_EXEC) && (s_r.chan == 4'(g));
            assign ch_if[g].cfg_word = s_r.ctl;
            assign ch_if[g].cmp_load = ch_if[g].cfg_load && s_r.code[tcp_pkg::CODE_LD_CMP];
            assign ch_if[g].cmp_val = s_r.cmp;
            assign match_ev[g] = ch_if[g].match_ev;
            assign cap_ev[g] = ch_if[g].cap_ev;
            assign cap_val[g] = ch_if[g].cap_val;
            assign pin_out_w[g] = ch_if[g].pin_out;
            assign pin_oe_w[g] = ch_if[g].pin_oe_n;
            tcp_chan u_chan
            (
                .clk(clk),
                .rst(rst),
                .cif(ch_if[g].chan)
            );
        end
    endgenerate

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        logic tick1;
        logic tick2;
        logic src2;
        logic [15:0] ready;
        logic [15:0] lvl_m;
        logic [1:0] lvl;
        logic [3:0] pick;
        logic [1:0] pri;
        logic [6:0] ha;
        logic [6:0] ea;
        tick1 = 1'b0;
        tick2 = 1'b0;
        src2 = 1'b0;
        ready = '0;
        lvl_m = '0;
        lvl = tcp_pkg::PRI_OFF;
        pick = '0;
        pri = tcp_pkg::PRI_OFF;
        ha = {pram_addr[6:1], pram_addr[0] & ~pram_long};
        ea = '0;
        s_nxt = s_r;

        // Time bases: wrap naturally and never stop
        s_nxt.pre1 = s_r.pre1 + 8'h01;
        tick1 = (s_r.pre1 & tcp_div_mask(cfg_tb1_prescale)) ==
                tcp_div_mask(cfg_tb1_prescale);
        if (tick1)
            s_nxt.tb1 = s_r.tb1 + 16'h0001;
        s_nxt.ext_q = external_time_base_clock_pin;
        src2 = cfg_tb2_ext_sel ? (external_time_base_clock_pin & ~s_r.ext_q) : 1'b1;
        if (src2)
        begin
            s_nxt.pre2 = s_r.pre2 + 8'h01;
            tick2 = (s_r.pre2 & tcp_div_mask(cfg_tb2_prescale)) ==
                    tcp_div_mask(cfg_tb2_prescale);
        end
        if (tick2)
            s_nxt.tb2 = s_r.tb2 + 16'h0001;

        // Ready channels by level, highest level first
        for (int c = 0; c < tcp_pkg::NCH; c++)
        begin
            pri = channel_priority[2*c +: 2];
            ready[c] = (pri != tcp_pkg::PRI_OFF) &&
                       (s_r.pend[0][c] | s_r.pend[1][c] | s_r.pend[2][c] | s_r.pend[3][c]);
        end
        for (int l = 1; l <= 3; l++)
        begin
            logic [15:0] m;
            m = '0;
            for (int c = 0; c < tcp_pkg::NCH; c++)
                m[c] = ready[c] && (channel_priority[2*c +: 2] == 2'(l));
            if (m != '0)
            begin
                lvl_m = m;
                lvl = 2'(l);
            end
        end

        // Engine sequence: grant, fetch code and parameters, execute
        case (s_r.st)
            ST_IDLE:
            begin
                if (lvl != tcp_pkg::PRI_OFF)
                begin
                    pick = tcp_next(lvl_m, s_r.last[lvl - 2'h1]);
                    s_nxt.last[lvl - 2'h1] = pick;
                    s_nxt.chan = pick;
                    s_nxt.st = ST_FETCH;
                    // One cause serviced per grant, fixed order among causes
                    if (s_r.pend[0][pick])
                        s_nxt.cause = tcp_pkg::CAUSE_HOST;
                    else if (s_r.pend[1][pick])
                        s_nxt.cause = tcp_pkg::CAUSE_LINK;
                    else if (s_r.pend[2][pick])
                        s_nxt.cause = tcp_pkg::CAUSE_MATCH;
                    else
                        s_nxt.cause = tcp_pkg::CAUSE_CAPT;
                    s_nxt.pend[s_nxt.cause][pick] = 1'b0;
                end
            end
            ST_FETCH:
            begin
                s_nxt.code = emu_select ? ucode_emu_data
                                        : tcp_rom({s_r.cause, s_r.chan});
                // Control and compare words read together, before any write lands
                s_nxt.ctl = s_r.pram[tcp_pw(s_r.chan, tcp_pkg::PW_CTL)];
                s_nxt.cmp = s_r.pram[tcp_pw(s_r.chan, tcp_pkg::PW_CMP)];
                s_nxt.st = ST_EXEC;
            end
            ST_EXEC:
            begin
                if (s_r.code[tcp_pkg::CODE_WR_CAP])
                begin
                    ea = tcp_pw(s_r.chan, tcp_pkg::PW_RES);
                    s_nxt.pram[ea] = cap_val[s_r.chan];
                end
                if (s_r.code[tcp_pkg::CODE_LINK_EN])
                    s_nxt.pend[1][s_r.code[3:0]] = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            default: s_nxt.st = ST_IDLE;
        endcase

        // New requests after the grant clear, so a same-cycle set survives
        for (int c = 0; c < tcp_pkg::NCH; c++)
        begin
            if (host_service_request[c])
                s_nxt.pend[0][c] = 1'b1;
            if (match_ev[c])
                s_nxt.pend[2][c] = 1'b1;
            if (cap_ev[c])
                s_nxt.pend[3][c] = 1'b1;
        end

        // Host writes land after the engine's, whole words only
        if (pram_wr)
        begin
            if (pram_long)
            begin
                if (tcp_impl(ha))
                    s_nxt.pram[ha] = pram_wdata[31:16];
                if (tcp_impl(ha + 7'h01))
                    s_nxt.pram[ha + 7'h01] = pram_wdata[15:0];
            end
            else if (tcp_impl(ha))
                s_nxt.pram[ha] = pram_wdata[15:0];
        end
        // Host reads see the word state from before this cycle
        if (pram_rd)
        begin
            s_nxt.host_rd = '0;
            if (pram_long)
            begin
                if (tcp_impl(ha))
                    s_nxt.host_rd[31:16] = s_r.pram[ha];
                if (tcp_impl(ha + 7'h01))
                    s_nxt.host_rd[15:0] = s_r.pram[ha + 7'h01];
            end
            else if (tcp_impl(ha))
                s_nxt.host_rd[15:0] = s_r.pram[ha];
        end

        // Host register space; every unmapped offset reads zero
        if (reg_rd)
        begin
            case (reg_addr)
                tcp_pkg::REG_CFG: s_nxt.reg_rd = {11'h000, cfg_tb2_ext_sel,
                                                  cfg_tb2_prescale, cfg_tb1_prescale};
                tcp_pkg::REG_PRI_LO: s_nxt.reg_rd = channel_priority[15:0];
                tcp_pkg::REG_PRI_HI: s_nxt.reg_rd = channel_priority[31:16];
                tcp_pkg::REG_PEND: s_nxt.reg_rd = s_r.pend[0] | s_r.pend[1] |
                                                  s_r.pend[2] | s_r.pend[3];
                tcp_pkg::REG_GRANT: s_nxt.reg_rd = {9'h000, s_r.st != ST_IDLE,
                                                    s_r.cause, s_r.chan};
                default: s_nxt.reg_rd = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // State register; round-robin pointers start so channel 0 goes first
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.tb1 <= tcp_pkg::TB_RST;
            s_r.tb2 <= tcp_pkg::TB_RST;
            s_r.last <= '1;
            s_r.st <= ST_IDLE;
            s_r.cause <= tcp_pkg::CAUSE_HOST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign ucode_addr = {s_r.cause, s_r.chan};
    assign pram_rdata = s_r.host_rd;
    assign reg_rdata = s_r.reg_rd;
    assign pin_out = pin_out_w;
    assign pin_oe_n = pin_oe_w;
    assign service_busy = s_r.st != ST_IDLE;
    assign service_chan = s_r.chan;
endmodule // tcp_core

// ---- tcp_core_sva.sv ----
// Port-level checker for the timing coprocessor core.
// Assumes one clock and a synchronous active-high reset; bound from the testbench.
`timescale 1ns/1ps
module tcp_core_sva
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] cfg_tb1_prescale,
    input wire logic [1:0] cfg_tb2_prescale,
    input wire logic cfg_tb2_ext_sel,
    input wire logic [31:0] channel_priority,
    input wire logic [5:0] ucode_addr,
    input wire logic [6:0] pram_addr,
    input wire logic pram_long,
    input wire logic pram_wr,
    input wire logic pram_rd,
    input wire logic [31:0] pram_wdata,
    input wire logic [31:0] pram_rdata,
    input wire logic [8:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] pin_oe_n,
    input wire logic service_busy,
    input wire logic [3:0] service_chan
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Host register and parameter RAM reads
    unmapped_zero_a: assert property (
        reg_rd && reg_addr >= 9'h00c |=> reg_rdata == 16'h0000) else $error("unmapped read");
    cfg_readback_a: assert property (
        reg_rd && reg_addr == 9'h000 |=> reg_rdata == {11'h000, $past(cfg_tb2_ext_sel),
        $past(cfg_tb2_prescale), $past(cfg_tb1_prescale)}) else $error("config readback");
    empty_slot_a: assert property (
        pram_rd && !pram_long && pram_addr[6:3] < 4'he && pram_addr[2:1] == 2'h3
        |=> pram_rdata == 32'h0) else $error("unimplemented slot not zero");
    // Long write then long read of the same pair must give the whole word back
    long_pair_a: assert property (
        pram_wr && pram_long && (pram_addr[6:3] >= 4'he || pram_addr[2:1] != 2'h3)
        ##1 !pram_wr && !service_busy ##1 pram_rd && pram_long
        && pram_addr == $past(pram_addr, 2) |=> pram_rdata == $past(pram_wdata, 3))
        else $error("long pair not coherent");
    // ==========================================================
    // Scheduler and engine
    busy_len_a: assert property (
        $rose(service_busy) |-> service_busy [*2] ##1 !service_busy) else $error("busy length");
    prio_off_a: assert property (
        $rose(service_busy) |-> channel_priority[{service_chan, 1'b0} +: 2] != 2'h0)
        else $error("disabled channel granted");
    code_chan_a: assert property (
        service_busy && $past(service_busy) |-> $stable(ucode_addr)
        && ucode_addr[3:0] == service_chan) else $error("code address channel");
    // Pins change direction only as the engine finishes a service
    dir_by_engine_a: assert property (
        $changed(pin_oe_n) |-> $past(service_busy)) else $error("direction without service");
    reset_pins_a: assert property (disable iff (1'b0)
        rst |=> pin_oe_n == 16'hffff && !service_busy) else $error("reset outputs");
    grant_c: cover property ($rose(service_busy));
    long_c: cover property (pram_rd && pram_long);
    unmapped_c: cover property (reg_rd && reg_addr >= 9'h00c);
endmodule // tcp_core_sva

// ---- tcp_pin_model.sv ----
// Far side of the channel pins: external logic that drives inputs.
// Assumes a driven pin is read back at its own level, as on a real pad.
`timescale 1ns/1ps
module tcp_pin_model
(
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    input wire logic [15:0] drive_lvl,
    output logic [15:0] pin_in
);
    // Core drives when enable is low, otherwise the outside world does
    assign pin_in = (pin_out & ~pin_oe_n) | (drive_lvl & pin_oe_n);
endmodule // tcp_pin_model

// ---- timing_coprocessor_core_tb.sv ----
// Self-checking testbench for the timing coprocessor core.
// Assumes 25 MHz clock; inputs change by non-blocking assignment at posedge, except prio which changes 1 ns after.
`timescale 1ns/1ps
module timing_coprocessor_core_tb;
    logic clk = 0, rst = 1, ext_sel = 1, pl = 0, pw = 0, prd = 0, rrd = 0, emu = 0;
    logic [1:0] p1 = 2'h2, p2 = 2'h1;
    logic [31:0] prio = 32'h0, wd = 32'h0, d;
    logic [15:0] hsr = 16'h0, ucd = 16'h0, pin_in, pin_out, oe_n, rdat;
    logic [6:0] pa = 7'h0;
    logic [8:0] ra = 9'h0;
    logic [31:0] prd_d;
    logic busy;
    logic [3:0] sch;
    int error_cnt = 0, n_tests = 0;
    // ==========================================================
    // Clock, design and pin partner
    initial forever #20 clk = ~clk;
    tcp_core u_dut (.clk(clk), .rst(rst), .cfg_tb1_prescale(p1), .cfg_tb2_prescale(p2),
        .cfg_tb2_ext_sel(ext_sel), .external_time_base_clock_pin(1'b0),
        .channel_priority(prio), .host_service_request(hsr), .emu_select(emu),
        .ucode_addr(), .ucode_emu_data(ucd), .pram_addr(pa), .pram_long(pl),
        .pram_wr(pw), .pram_rd(prd), .pram_wdata(wd), .pram_rdata(prd_d), .reg_addr(ra),
        .reg_rd(rrd), .reg_rdata(rdat), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(oe_n), .service_busy(busy), .service_chan(sch));
    tcp_pin_model u_pins (.pin_out(pin_out), .pin_oe_n(oe_n), .drive_lvl(16'h00f0),
        .pin_in(pin_in));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Access tasks: strobe for one edge, answer sampled just after the next
    task pwr(input logic [6:0] a, input logic l, input logic [31:0] v);
        @(posedge clk);
        pa <= a; pl <= l; wd <= v; pw <= 1'b1;
        @(posedge clk);
        pw <= 1'b0;
    endtask
    task prdw(input logic [6:0] a, input logic l);
        @(posedge clk);
        pa <= a; pl <= l; prd <= 1'b1;
        @(posedge clk);
        prd <= 1'b0;
        #1 d = prd_d;
    endtask
    task rrdw(input logic [8:0] a);
        @(posedge clk);
        ra <= a; rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1 d = {16'h0, rdat};
    endtask
    // Wait for a grant under a bound, check its channel, then let it finish
    task grant(input logic [3:0] ch);
        int i;
        #1;
        for (i = 0; i < 40 && busy !== 1'b1; i++) @(posedge clk) #1;
        chk({busy, sch}, {1'b1, ch});
        repeat (3) @(posedge clk);
        #1;
    endtask
    task req(input logic [15:0] m);
        @(posedge clk);
        hsr <= m;
        @(posedge clk);
        hsr <= 16'h0;
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1 chk(oe_n, 32'hffff);
        prio <= 32'h000c_08c0; // ch3 high, ch5 mid, ch9 high, ch6 and ch7 off
        rrdw(9'h000); chk(d, 32'h0000_0016);
        rrdw(9'h004); chk(d, 32'h0000_08c0);
        rrdw(9'h006); chk(d, 32'h0000_000c);
        rrdw(9'h100); chk(d, 32'h0);
        rrdw(9'h1fe); chk(d, 32'h0);
        pwr(7'h10, 1'b1, 32'hbeef_1234);
        prdw(7'h10, 1'b1); chk(d, 32'hbeef_1234);
        prdw(7'h11, 1'b0); chk(d, 32'h0000_1234);
        pwr(7'h06, 1'b0, 32'h0000_5a5a);
        prdw(7'h06, 1'b0); chk(d, 32'h0);
        pwr(7'h76, 1'b0, 32'h0000_a5a5);
        prdw(7'h76, 1'b0); chk(d, 32'h0000_a5a5);
        pwr(7'h18, 1'b0, 32'h0000_0011); // output, forced high
        req(16'h0008); grant(4'h3);
        chk({oe_n[3], pin_out[3]}, 32'h1);
        pwr(7'h18, 1'b0, 32'h0000_0012); // output, forced low
        req(16'h0008); grant(4'h3);
        chk({oe_n[3], pin_out[3]}, 32'h0);
        // Channel 3 armed at compare zero, so its match service must drain first
        repeat (8) @(posedge clk);
        req(16'h0220); grant(4'h9);
        grant(4'h5);
        req(16'h0080);
        repeat (10) @(posedge clk);
        #1 chk(busy, 32'h0);
        rrdw(9'h008); chk(d, 32'h0000_0080);
        // Emulation code links to channel 6, which is off, so it stays pending
        @(posedge clk); emu <= 1'b1; ucd <= 16'h0016;
        req(16'h0008); grant(4'h3);
        rrdw(9'h008); chk(d, 32'h0000_00c0);
        print_verdict();
    end
endmodule // timing_coprocessor_core_tb
bind tcp_core tcp_core_sva u_sva (.clk(clk), .rst(rst), .cfg_tb1_prescale(cfg_tb1_prescale),
    .cfg_tb2_prescale(cfg_tb2_prescale), .cfg_tb2_ext_sel(cfg_tb2_ext_sel),
    .channel_priority(channel_priority), .ucode_addr(ucode_addr), .pram_addr(pram_addr),
    .pram_long(pram_long), .pram_wr(pram_wr), .pram_rd(pram_rd), .pram_wdata(pram_wdata),
    .pram_rdata(pram_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_oe_n(pin_oe_n), .service_busy(service_busy), .service_chan(service_chan));
